// [bench/sab_periph.sv]
// Behavioural peripheral answering the data strobe with a delayed acknowledge.
// Assumes storage indexed by the low address byte.
`timescale 1ns/1ns
module sab_periph (
    input  wire logic        clk,
    input  wire logic [23:0] bus_addr,
    input  wire logic        bus_read_n_write,
    input  wire logic        data_strobe_n,
    input  wire logic [7:0]  bus_data_out,
    input  wire logic        bus_data_oe,
    input  wire logic [7:0]  ack_delay,
    output wire logic        transfer_ack_n,
    output wire logic [7:0]  bus_data_in
);
    logic [7:0] mem [0:255];
    logic [7:0] cnt_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    // Asynchronous acknowledge: follows the data strobe after the delay, drops with it
    assign transfer_ack_n = data_strobe_n || (cnt_q < ack_delay);
    // Read data only while acknowledging, else the inverse of the last value
    assign bus_data_in = (!transfer_ack_n && bus_read_n_write) ? mem[bus_addr[7:0]] : ~last_q;
    // Count strobed clocks and store written bytes
    always @(posedge clk) begin
        last_q <= bus_data_in;
        if (data_strobe_n) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            if (!bus_read_n_write && bus_data_oe) mem[bus_addr[7:0]] <= bus_data_out;
        end
    end
endmodule

// [bench/sab_props.sv]
// Port checker for the strobe/acknowledge bus sequencer.
// Assumes a bind onto sab_sequencer with its default widths.
`timescale 1ns/1ns
module sab_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        done,
    input wire logic        busy,
    input wire logic        inserted_wait_state,
    input wire logic [23:0] bus_addr,
    input wire logic        bus_read_n_write,
    input wire logic        address_strobe_n,
    input wire logic        data_strobe_n,
    input wire logic        bus_data_oe,
    input wire logic        transfer_ack_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Strobe relations, direction and hold rules
    chk_strobe_order: assert property (!data_strobe_n |-> !address_strobe_n)
        else $error("data strobe without address strobe");
    chk_strobes_drop: assert property ($rose(address_strobe_n) |-> $rose(data_strobe_n))
        else $error("strobes not released together");
    chk_write_dir: assert property (bus_data_oe |-> !bus_read_n_write)
        else $error("data driven while direction reads");
    chk_ack_first: assert property ($rose(address_strobe_n) |-> !$past(transfer_ack_n))
        else $error("cycle ended without acknowledge");
    chk_wait_strobed: assert property (inserted_wait_state |-> !data_strobe_n)
        else $error("wait state outside strobed phase");
    chk_wait_period: assert property ($rose(inserted_wait_state) |-> inserted_wait_state[*2])
        else $error("wait state shorter than a bus state");
    chk_bus_hold: assert property ((!address_strobe_n && !$fell(address_strobe_n))
        |-> $stable({bus_addr, bus_read_n_write}))
        else $error("bus changed while strobed");
    chk_done_idle: assert property (done |-> !busy && address_strobe_n
        && bus_read_n_write && !bus_data_oe)
        else $error("bus not idle at cycle end");
    // Main scenarios reached
    cover property ($rose(inserted_wait_state));
    cover property (done && bus_read_n_write);
    cover property (done && !$past(bus_read_n_write));
endmodule
bind sab_sequencer sab_chk sab_chk_i (.clk(clk), .rst_n(rst_n), .done(done), .busy(busy),
    .inserted_wait_state(inserted_wait_state), .bus_addr(bus_addr),
    .bus_read_n_write(bus_read_n_write), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .bus_data_oe(bus_data_oe), .transfer_ack_n(transfer_ack_n));

// [bench/tb.sv]
// Top-level bench: drives requests and checks each finished transfer.
// Assumes the sequencer, its checker and the peripheral model are compiled.
`timescale 1ns/1ns
module tb;
    logic        clk, rst_n, req_valid, req_write, req_ready, done, busy, waitst;
    logic        rw, as_n, ds_n, oe, ack_n;
    logic [1:0]  req_mode, last_mode;
    logic [23:0] req_addr, bus_addr;
    logic [7:0]  req_wdata, rdata, dout, din, dly;
    logic [31:0] lfsr;
    logic [34:0] exp_n;
    logic [34:0] expq [$];
    logic [7:0]  shadow [0:255];
    int          failures, samples_checked, cyc, t_take, waits;
    sab_sequencer sab_sequencer_i (.clk(clk), .rst_n(rst_n), .ce(1'b1), .clk_per_state(4'h2),
        .req_valid(req_valid), .req_write(req_write), .req_mode(req_mode), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .done(done), .rdata(rdata), .busy(busy),
        .inserted_wait_state(waitst), .bus_addr(bus_addr), .bus_read_n_write(rw),
        .address_strobe_n(as_n), .data_strobe_n(ds_n), .bus_data_out(dout), .bus_data_oe(oe),
        .bus_data_in(din), .transfer_ack_n(ack_n));
    sab_periph sab_periph_i (.clk(clk), .bus_addr(bus_addr), .bus_read_n_write(rw),
        .data_strobe_n(ds_n), .bus_data_out(dout), .bus_data_oe(oe), .ack_delay(dly),
        .transfer_ack_n(ack_n), .bus_data_in(din));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        samples_checked++;
        if (seen !== want) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One transfer: note the expectation, hold the request until taken, await the end
    task automatic run_op(input logic wr, input logic [1:0] mode, input logic [7:0] idx,
                          input logic [7:0] delay_c);
        lfsr = lfsr_next(lfsr);
        if (wr) shadow[idx] = lfsr[23:16];
        @(posedge clk);
        dly <= delay_c;
        req_valid <= 1'b1;
        req_write <= wr;
        req_mode <= mode;
        req_addr <= {lfsr[15:0], idx};
        req_wdata <= lfsr[23:16];
        expq.push_back({lfsr[15:0], idx, delay_c > 8'h08, !wr,
                        mode != last_mode && mode != 2'h0, shadow[idx]});
        last_mode = mode;
        do @(posedge clk); while (req_ready !== 1'b1);
        t_take = cyc;
        req_valid <= 1'b0;
        do @(posedge clk); while (done !== 1'b1);
    endtask
    // Compare each finished transfer with the oldest note
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rst_n && waitst === 1'b1) waits <= waits + 1;
        if (rst_n && done === 1'b1) begin
            exp_n = expq.pop_front();
            check(cyc - t_take - waits, 16 + exp_n[8]);
            check(waits % 2, 0);
            check(waits != 0, exp_n[10]);
            if (exp_n[9]) check(rdata, exp_n[7:0]);
            check(bus_addr, exp_n[34:11]);
            waits <= 0;
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Writes then reads back, across mode switches and slow acknowledges
    initial begin
        {rst_n, req_valid, req_write, req_mode, req_addr, req_wdata, dly} = '0;
        {failures, samples_checked, cyc, t_take, waits} = '0;
        lfsr = 32'h0000_fc7e;
        last_mode = 2'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            run_op(k < 8, 2'(16'hf0cf >> (2 * (k % 8))), 8'(k % 8), k[0] ? 8'h0c : 8'h00);
        end
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule

// [src/sab_defines.vh]
// Constants for the strobe/acknowledge bus sequencer.
// Assumes inclusion by bare name from the design files; definitions only.
// Behaviour
// - Read cycle S0 drives direction line high (read).
// - Read cycle presents valid address on entering S1.
// - Read cycle asserts address and data strobes at start of S2.
// - Read S4 waits for acknowledge, inserting wait states if it is late.
// - Each wait state lasts one full bus state period.
// - Read S5 leaves all bus outputs unchanged.
// - Entering read S7, capture data and deassert both strobes.
// - Write S0 returns direction line high if left low.
// - Write cycle presents valid address on entering S1.
// - Write S2 asserts address strobe and drives direction line low.
// - Write S3 enables data bus drivers with the write data.
// - Write S4 asserts data strobe, then waits for acknowledge likewise.
// - Write S5 and S6 hold every bus output unchanged.
// - Entering write S7 drop strobes; end of S7 direction high.
// - Switching to a different non-native bus mode costs one clock first.
// - No extra clock for same mode or switch into native mode.
`ifndef SAB_DEFINES_VH
`define SAB_DEFINES_VH

`define SAB_ADDR_W      24
`define SAB_DATA_W      8
`define SAB_MODE_W      2
`define SAB_MODE_NATIVE 2'h0
`define SAB_MODE_STROBE 2'h3
`define SAB_CLK_PER_ST  2
`define SAB_CNT_W       4
`define SAB_LAST_STATE  3'h7
`define SAB_WAIT_STATE  3'h4
`define SAB_DATA_STATE  3'h3
`define SAB_STRB_STATE  3'h2
`define SAB_ST_S0       3'h0
`define SAB_ST_S1       3'h1
`define SAB_ST_S6       3'h6

`endif

// [src/sab_mode_gap.v]
// Bus mode change detector: asks for one idle clock on a switch to a non-native mode.
// Assumes the caller pulses start with the requested mode.
`timescale 1ns/1ns
`include "sab_defines.vh"
module sab_mode_gap #(
    parameter MODE_W = `SAB_MODE_W
) (
    input  wire              clk,
    input  wire              rst_n,
    input  wire              ce,
    input  wire              start,
    input  wire [MODE_W-1:0] mode,
    output wire              need_gap
);
    reg [MODE_W-1:0] last_mode_q;

    // Gap only for a different mode, never when entering native mode
    assign need_gap = (mode != last_mode_q) && (mode != `SAB_MODE_NATIVE);

    // Remember the mode of the last accepted access
    always @(posedge clk) begin
        if (!rst_n) begin
            last_mode_q <= `SAB_MODE_NATIVE;
        end else if (ce && start) begin
            last_mode_q <= mode;
        end
    end
endmodule

// [src/sab_sequencer.v]
// Eight-state strobe/acknowledge external bus cycle sequencer.
// Assumes requests arrive synchronous to clk and the acknowledge
// input is already synchronised; the data bus tristate is resolved outside.
`timescale 1ns/1ns
`include "sab_defines.vh"
module sab_sequencer #(
    parameter ADDR_W = `SAB_ADDR_W,
    parameter DATA_W = `SAB_DATA_W,
    parameter MODE_W = `SAB_MODE_W,
    parameter CNT_W  = `SAB_CNT_W
) (
    input  wire              clk,
    input  wire              rst_n,
    input  wire              ce,
    input  wire [CNT_W-1:0]  clk_per_state,
    input  wire              req_valid,
    input  wire              req_write,
    input  wire [MODE_W-1:0] req_mode,
    input  wire [ADDR_W-1:0] req_addr,
    input  wire [DATA_W-1:0] req_wdata,
    output reg               req_ready,
    output reg               done,
    output reg  [DATA_W-1:0] rdata,
    output reg               busy,
    output reg               inserted_wait_state,
    output reg  [ADDR_W-1:0] bus_addr,
    output reg               bus_read_n_write,
    output reg               address_strobe_n,
    output reg               data_strobe_n,
    output reg  [DATA_W-1:0] bus_data_out,
    output reg               bus_data_oe,
    input  wire [DATA_W-1:0] bus_data_in,
    input  wire              transfer_ack_n
);
    // One-hot controller states
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_GAP  = 4'b0010;
    localparam [3:0] ST_RUN  = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;

    reg [3:0]        st_q;
    reg [3:0]        st_d;
    reg [2:0]        bstate_q;
    reg              write_q;
    reg [ADDR_W-1:0] addr_q;
    reg [DATA_W-1:0] wdata_q;
    reg              ack_seen_q;
    wire             state_end;
    wire             need_gap;
    wire             accept;
    wire             running;
    wire             in_run;
    wire             in_wait;
    wire             in_ack_state;
    wire             ack_sample;
    wire             go_wait;
    wire             leave_wait;
    wire             finish;
    wire             advance;
    wire             step;
    wire             enter_s1;
    wire             enter_s2;
    wire             enter_s3;
    wire             enter_s4;
    wire             enter_s7;
    wire             read_strobe;
    wire             write_strobe;
    wire             load_wdata;
    wire             latch_rdata;

    // Controller decode
    assign accept  = (st_q == ST_IDLE) && req_valid;
    assign in_run  = (st_q == ST_RUN);
    assign in_wait = (st_q == ST_WAIT);
    assign running = in_run || in_wait;

    // Acknowledge window: S4 itself and every inserted wait state
    assign in_ack_state = in_run && (bstate_q == `SAB_WAIT_STATE);
    assign ack_sample   = !transfer_ack_n && (in_ack_state || in_wait);

    // End-of-state decisions; a late acknowledge turns the end of S4 into a wait
    assign go_wait    = in_ack_state && state_end && !ack_seen_q;
    assign leave_wait = in_wait && state_end && ack_seen_q;
    assign finish     = in_run && state_end && (bstate_q == `SAB_LAST_STATE);
    assign advance    = in_run && state_end && !go_wait && !finish;
    assign step       = advance || leave_wait;

    // Entry strobes; S5 and S6 have none, so the bus holds there
    assign enter_s1 = advance && (bstate_q == `SAB_ST_S0);
    assign enter_s2 = advance && (bstate_q == `SAB_ST_S1);
    assign enter_s3 = advance && (bstate_q == `SAB_STRB_STATE);
    assign enter_s4 = advance && (bstate_q == `SAB_DATA_STATE);
    assign enter_s7 = advance && (bstate_q == `SAB_ST_S6);

    // Direction-qualified strobes
    assign read_strobe  = enter_s2 && !write_q;
    assign write_strobe = enter_s4 && write_q;
    assign load_wdata   = enter_s3 && write_q;
    assign latch_rdata  = enter_s7 && !write_q;

    // State period timer, reused for wait states
    sab_state_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clk           (clk),
        .rst_n         (rst_n),
        .ce            (ce),
        .run           (running),
        .clk_per_state (clk_per_state),
        .state_end     (state_end)
    );

    // Mode switch gap decision
    sab_mode_gap #(
        .MODE_W(MODE_W)
    ) u_gap (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .start    (accept),
        .mode     (req_mode),
        .need_gap (need_gap)
    );

    // Next controller state; a switch to a non-native mode costs one idle clock first
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (req_valid && need_gap) begin
                    st_d = ST_GAP;
                end else if (req_valid) begin
                    st_d = ST_RUN;
                end
            end
            ST_GAP: begin
                st_d = ST_RUN;
            end
            ST_RUN: begin
                if (go_wait) begin
                    st_d = ST_WAIT;
                end else if (finish) begin
                    st_d = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (leave_wait) begin
                    st_d = ST_RUN;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Controller state register
    always @(posedge clk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // Bus state counter: restarts at S0 on accept, steps at each state end before S7 unless a wait state follows
    always @(posedge clk) begin
        if (!rst_n) begin
            bstate_q <= `SAB_ST_S0;
        end else if (ce) begin
            if (accept) begin
                bstate_q <= `SAB_ST_S0;
            end else if (step) begin
                bstate_q <= bstate_q + 3'h1;
            end
        end
    end

    // Acknowledge flag; a fresh sample wins over the clear on a state step
    always @(posedge clk) begin
        if (!rst_n) begin
            ack_seen_q <= 1'b0;
        end else if (ce) begin
            if (ack_sample) begin
                ack_seen_q <= 1'b1;
            end else if (step || accept) begin
                ack_seen_q <= 1'b0;
            end
        end
    end

    // Request capture at acceptance
    always @(posedge clk) begin
        if (!rst_n) begin
            write_q <= 1'b0;
            addr_q  <= {ADDR_W{1'b0}};
            wdata_q <= {DATA_W{1'b0}};
        end else if (ce && accept) begin
            write_q <= req_write;
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
        end
    end

    // Handshake pulses and busy level
    always @(posedge clk) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
            done      <= 1'b0;
            busy      <= 1'b0;
        end else if (ce) begin
            req_ready <= accept;
            done      <= finish;
            if (accept) begin
                busy <= 1'b1;
            end else if (finish) begin
                busy <= 1'b0;
            end
        end
    end

    // Wait-state indicator, high for whole state periods
    always @(posedge clk) begin
        if (!rst_n) begin
            inserted_wait_state <= 1'b0;
        end else if (ce) begin
            if (go_wait) begin
                inserted_wait_state <= 1'b1;
            end else if (leave_wait) begin
                inserted_wait_state <= 1'b0;
            end
        end
    end

    // Address bus: loaded on S1 entry only, so it holds through S5 and S6
    always @(posedge clk) begin
        if (!rst_n) begin
            bus_addr <= {ADDR_W{1'b0}};
        end else if (ce && enter_s1) begin
            bus_addr <= addr_q;
        end
    end

    // Direction line: high at S0 and after S7, low from S2 of a write
    always @(posedge clk) begin
        if (!rst_n) begin
            bus_read_n_write <= 1'b1;
        end else if (ce) begin
            if (accept || finish) begin
                bus_read_n_write <= 1'b1;
            end else if (enter_s2 && write_q) begin
                bus_read_n_write <= 1'b0;
            end
        end
    end

    // Address strobe: asserted from S2 until S7 entry
    always @(posedge clk) begin
        if (!rst_n) begin
            address_strobe_n <= 1'b1;
        end else if (ce) begin
            if (enter_s2) begin
                address_strobe_n <= 1'b0;
            end else if (enter_s7) begin
                address_strobe_n <= 1'b1;
            end
        end
    end

    // Data strobe: from S2 on a read, from S4 on a write, off at S7 entry
    always @(posedge clk) begin
        if (!rst_n) begin
            data_strobe_n <= 1'b1;
        end else if (ce) begin
            if (read_strobe) begin
                data_strobe_n <= 1'b0;
            end else if (write_strobe) begin
                data_strobe_n <= 1'b0;
            end else if (enter_s7) begin
                data_strobe_n <= 1'b1;
            end
        end
    end

    // Write data driver: enabled from S3 until the cycle ends
    always @(posedge clk) begin
        if (!rst_n) begin
            bus_data_out <= {DATA_W{1'b0}};
            bus_data_oe  <= 1'b0;
        end else if (ce) begin
            if (load_wdata) begin
                bus_data_out <= wdata_q;
                bus_data_oe  <= 1'b1;
            end else if (finish) begin
                bus_data_oe <= 1'b0;
            end
        end
    end

    // Read data latch on S7 entry
    always @(posedge clk) begin
        if (!rst_n) begin
            rdata <= {DATA_W{1'b0}};
        end else if (ce && latch_rdata) begin
            rdata <= bus_data_in;
        end
    end
endmodule

// [src/sab_state_timer.v]
// State period timer: pulses at the last clock of each bus state.
// Assumes a synchronous active-low reset and a clock enable.
`timescale 1ns/1ns
`include "sab_defines.vh"
module sab_state_timer #(
    parameter CNT_W = `SAB_CNT_W
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             ce,
    input  wire             run,
    input  wire [CNT_W-1:0] clk_per_state,
    output wire             state_end
);
    reg [CNT_W-1:0] cnt_q;

    // Last clock of a state when the count reaches the period less one
    assign state_end = run && (cnt_q == clk_per_state - {{(CNT_W-1){1'b0}}, 1'b1});

    // Count clocks within one state period
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= {CNT_W{1'b0}};
        end else if (ce) begin
            if (!run || state_end) begin
                cnt_q <= {CNT_W{1'b0}};
            end else begin
                cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
